/* File: design/fdc_host_port.sv */
// host port, wait-state and reset logic of the floppy controller board
`default_nettype none
// Overview of operation
// R1 - wait-state, polled and interrupt transfer modes
// R2 - written byte held in latch for core
// R3 - latch enabled only on captured output cycle
// R4 - status or core data buffered to bus
// R5 - pull RDY low during waits, then release
// R6 - read-only status port with drive facts
// R7 - control latch takes drive select and step
// R8 - precompensate only double-density writes
// R9 - each interface selects up to four drives
// R10 - bus reset defines core, latch, waits
// R11 - reset loads 03h command, 01h sector
// R12 - after reset core restores to track zero
// R13 - reset clears all control latch outputs
// R14 - reset forces pll phase four low
// R15 - reset sets both wait flip-flops high
// R16 - wait holds RDY until request plus delay
// R17 - reset or core interrupt ends wait
// R18 - wait and capture flops clocked, async reset
module fdc_host_port
  import fdc_port_pkg::*;
(
  input  wire logic        clk_sys,        // bus system clock
  input  wire logic        rst_n,          // bus reset, active low
  input  wire s100_in_t    busIn,          // bus pins
  input  wire logic [4:0]  boardAddr,      // address switch a7..a3
  input  wire drive_stat_t driveStat,      // drive status pins
  output logic [7:0]       dataIn,         // data toward master
  output logic             dataInOe,       // data-in drive enable
  output logic             rdyOut,         // RDY pin level
  output logic             rdyOe,          // RDY pulled low while high
  output logic             intOut,         // interrupt to master
  input  wire logic [7:0]  coreReadData,   // core data bus out
  input  wire logic        coreDrq,        // core_data_request
  input  wire logic        coreIntrq,      // core_interrupt_request
  input  wire logic        coreWriteGate,  // core write gate
  output logic [7:0]       coreWriteData,  // held write byte
  output logic [1:0]       coreAddr,       // core register select
  output logic             coreRd,         // core read strobe
  output logic             coreWr,         // core write strobe
  output logic             coreResetN,     // core reset, active low
  output logic [7:0]       coreCmdPreset,  // command register image
  output logic [7:0]       coreSectorPreset, // sector register image
  output logic             coreNotReady,   // status bit 7 image
  output logic             coreRestore,    // restore start pulse
  output ctl_t             ctlOut,         // control latch outputs
  output logic [3:0]       sel5,           // 5.25 inch drive selects
  output logic [3:0]       sel8,           // 8 inch drive selects
  output logic             driveWriteGate, // write gate to drives
  output logic             precompEnable,  // precompensation on
  output logic             pllPhase4       // pll phase four input
);

  // whole state of the port in one record, except the reset release pipe
  typedef struct packed {
    s100_in_t    busMeta;   // first sync stage, read only by busSync
    s100_in_t    busSync;   // second sync stage
    drive_stat_t statMeta;  // first sync stage of status pins
    drive_stat_t statSync;  // second sync stage
    logic        selected;  // captured board select
    logic        outCycle;  // captured output status
    logic        inCycle;   // captured input status
    logic [2:0]  port;      // captured low address
    logic        wrLast;    // write strobe one clock ago
    logic [7:0]  holdData;  // write_data_hold_latch
    logic [7:0]  dataIn;    // read_data_buffer
    logic        dataInOe;  // buffer enable
    ctl_t        ctl;       // drive_control_latch
    logic [7:0]  cmdImg;    // command register image
    logic [7:0]  sectorImg; // sector register image
    logic        notReady;  // status bit 7 image
    wait_state_t waitSt;    // wait_state_flipflops sequencer
    logic [1:0]  delayCnt;  // clocks counted after request
    logic        rdy;       // ready toward master
    logic        accessQual; // core access qualifier
    logic        phase4;    // pll_control_unit phase four
    logic        restoreDone; // restore already issued
    logic        restorePulse; // restore start pulse
    logic        intReq;    // interrupt toward master
  } state_t;

  state_t     st;      // registered state
  state_t     next_st; // next state
  logic [1:0] rstPipe; // reset release pipe
  logic       rstSync; // released reset

  // true when the low address selects a core register
  function automatic logic isCorePort(input logic [2:0] p);
    isCorePort = !p[2];
  endfunction

  // reset is taken at once and released through two flops
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstSync = rstPipe[1];

  // derived strobes from synced pins
  logic readActive;  // board read in progress
  logic writeActive; // board write in progress
  logic wrStart;     // write strobe just went active
  logic aleCapture;  // cycle status valid now
  logic delayDone;   // access delay reached
  assign readActive  = st.selected && st.inCycle && st.busSync.pDbin;
  assign writeActive = st.selected && st.outCycle && !st.busSync.pWrN;
  assign wrStart     = writeActive && st.wrLast;
  assign aleCapture  = st.busSync.pSync && !st.busSync.pStvalN;
  assign delayDone   = (st.delayCnt + 2'h1) ==
                       (st.statSync.waitTwoClk ? DELAY_LONG : DELAY_SHORT); // R16

  // next state
  always_comb
  begin
    next_st = st;
    // bus and drive status pins pass two flops before use
    next_st.busMeta  = busIn;
    next_st.busSync  = st.busMeta;
    next_st.statMeta = driveStat;
    next_st.statSync = st.statMeta;
    next_st.wrLast   = st.busSync.pWrN;
    // cycle capture at address latch time
    if (aleCapture) // R18
    begin
      next_st.selected = (st.busSync.addr[7:3] == boardAddr) &&
                         (st.busSync.sOut || st.busSync.sInp);
      next_st.outCycle = st.busSync.sOut;
      next_st.inCycle  = st.busSync.sInp;
      next_st.port     = st.busSync.addr[2:0];
    end
    // every board write lands in the hold latch
    if (writeActive) // R2 R3
      next_st.holdData = st.busSync.dataOut;
    // control latch and register images on write start
    if (wrStart)
    begin
      if (st.port == PORT_CONTROL)
        next_st.ctl = ctl_t'(st.busSync.dataOut); // R7
      if (st.port == PORT_CORE_CMD && st.accessQual)
        next_st.cmdImg = st.busSync.dataOut;
      if (st.port == PORT_CORE_SECTOR && st.accessQual)
        next_st.sectorImg = st.busSync.dataOut;
    end
    // read buffer, status port or core
    next_st.dataInOe = readActive; // R4
    if (readActive && st.port == PORT_STATUS)
    begin
      next_st.dataIn                = 8'h00; // R6
      next_st.dataIn[STAT_CORE_INTERRUPT_REQUEST]    = coreIntrq;
      next_st.dataIn[STAT_MOTOR]    = st.statSync.motorOn;
      next_st.dataIn[STAT_TPI96]    = st.statSync.tpi96;
      next_st.dataIn[STAT_PRECOMP]  = st.statSync.precompNeed;
      next_st.dataIn[STAT_TWOSIDED] = st.statSync.twoSided;
      next_st.dataIn[STAT_DRQ]      = coreDrq; // R1
    end
    else if (readActive && isCorePort(st.port))
      next_st.dataIn = coreReadData; // R4
    // wait sequencer
    case (st.waitSt)
      W_IDLE:
      begin
        // a fresh data register access arms the wait
        if (aleCapture && st.ctl.waitMode &&
            st.busSync.addr[7:3] == boardAddr &&
            (st.busSync.sOut || st.busSync.sInp) &&
            st.busSync.addr[2:0] == PORT_CORE_DATA) // R5 R16
        begin
          next_st.waitSt     = W_DRQ;
          next_st.rdy        = 1'b0;
          next_st.accessQual = 1'b0;
        end
      end
      W_DRQ:
      begin
        // stay stalled until the core asks for data
        if (coreDrq) // R16
        begin
          next_st.waitSt   = W_DELAY;
          next_st.delayCnt = 2'h0;
        end
      end
      W_DELAY:
      begin
        // access time of the core plus bus sync
        if (delayDone) // R16
        begin
          next_st.waitSt     = W_IDLE;
          next_st.rdy        = 1'b1; // R5
          next_st.accessQual = 1'b1;
        end
        else
          next_st.delayCnt = st.delayCnt + 2'h1;
      end
      default:
        next_st.waitSt = W_IDLE;
    endcase
    // an error interrupt must not leave the master hung
    if (coreIntrq) // R17
    begin
      next_st.waitSt     = W_IDLE;
      next_st.rdy        = 1'b1;
      next_st.accessQual = 1'b1;
    end
    // phase four runs only for double density
    next_st.phase4 = st.ctl.driveEnable && !st.ctl.singleDensity;
    // one restore start after the reset release
    next_st.restoreDone  = 1'b1; // R12
    next_st.restorePulse = !st.restoreDone;
    // track zero found and other interrupts go out
    next_st.intReq = coreIntrq; // R1 R12
  end

  // state register, all defined by bus reset
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync) // R10 R18
    begin
      st            <= '0;
      st.busMeta.pWrN    <= 1'b1;
      st.busSync.pWrN    <= 1'b1;
      st.busMeta.pStvalN <= 1'b1;
      st.busSync.pStvalN <= 1'b1;
      st.wrLast     <= 1'b1;
      st.ctl        <= ctl_t'(CTL_RESET); // R13
      st.cmdImg     <= CORE_CMD_RESET;    // R11
      st.sectorImg  <= CORE_SECTOR_RESET; // R11
      st.notReady   <= 1'b0;              // R11
      st.waitSt     <= W_IDLE;
      st.rdy        <= 1'b1; // R15
      st.accessQual <= 1'b1; // R15
      st.phase4     <= 1'b0; // R14
    end
    else
      st <= next_st;
  end

  // outputs
  assign dataIn           = st.dataIn;
  assign dataInOe         = st.dataInOe;
  assign rdyOut           = 1'b0;
  assign rdyOe            = !st.rdy; // R5
  assign intOut           = st.intReq;
  assign coreWriteData    = st.holdData; // R2
  assign coreAddr         = st.port[1:0];
  // core strobes wait for the qualifier flop
  assign coreRd           = readActive && isCorePort(st.port) && st.accessQual;
  assign coreWr           = writeActive && isCorePort(st.port) && st.accessQual;
  assign coreResetN       = rstSync; // R10
  assign coreCmdPreset    = st.cmdImg;
  assign coreSectorPreset = st.sectorImg;
  assign coreNotReady     = st.notReady;
  assign coreRestore      = st.restorePulse; // R12
  assign ctlOut           = st.ctl;
  // one of four drives on the chosen interface
  always_comb
  begin
    sel5 = 4'h0;
    sel8 = 4'h0;
    if (st.ctl.driveEnable && st.ctl.size8) // R9
      sel8[st.ctl.driveSel] = 1'b1;
    else if (st.ctl.driveEnable)
      sel5[st.ctl.driveSel] = 1'b1;
  end
  assign driveWriteGate = coreWriteGate && st.ctl.driveEnable;
  // single density never precompensates
  assign precompEnable  = driveWriteGate && !st.ctl.singleDensity && !st.ctl.precompOff; // R8
  assign pllPhase4      = st.phase4; // R14

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSync);

  sequence armSeq;
    st.waitSt == W_IDLE && aleCapture && st.ctl.waitMode && !coreIntrq &&
    st.busSync.addr[7:3] == boardAddr && st.busSync.sInp &&
    st.busSync.addr[2:0] == PORT_CORE_DATA;
  endsequence
  sequence drqSeq;
    st.waitSt == W_DRQ && coreDrq && !coreIntrq;
  endsequence

  a_hold_capture: assert property (writeActive |=> st.holdData == $past(st.busSync.dataOut)) // R2
    else $error("hold latch missed a write");
  a_hold_guard: assert property (!writeActive |=> $stable(st.holdData)) // R3
    else $error("hold latch changed outside a write");
  a_read_buffer: assert property (readActive |=> dataInOe) // R4
    else $error("read buffer not enabled");
  a_wait_entry: assert property (armSeq |=> rdyOe && !coreRd && !coreWr) // R5
    else $error("wait not entered on data access");
  a_wait_release: assert property (drqSeq ##1 (!coreIntrq)[*2] |-> ##[1:2] !rdyOe) // R16
    else $error("RDY not released after request");
  a_wait_hold: assert property (st.waitSt == W_DRQ && !coreDrq && !coreIntrq |=> rdyOe) // R16
    else $error("RDY released before request");
  a_core_interrupt_request_clear: assert property (coreIntrq |=> !rdyOe && st.waitSt == W_IDLE) // R17
    else $error("interrupt did not clear wait");
  a_ctl_write: assert property (wrStart && st.port == PORT_CONTROL |=> ctlOut == $past(st.busSync.dataOut)) // R7
    else $error("control latch not written");
  a_precomp_sd: assert property (precompEnable |-> !ctlOut.singleDensity && driveWriteGate) // R8
    else $error("precompensation in single density");
  a_drive_sel: assert property ($onehot0({sel5, sel8}) && ((sel5 | sel8) != 4'h0) == ctlOut.driveEnable) // R9
    else $error("drive select not one of four");
  a_status_rd: assert property (readActive && st.port == PORT_STATUS |=> dataIn[STAT_DRQ] == $past(coreDrq)) // R6
    else $error("status port drq bit wrong");
endmodule
`default_nettype wire

/* File: shared/fdc_port_pkg.sv */
// constants and carrier types for the floppy board host port
`default_nettype none
package fdc_port_pkg;
  // port offsets, decoded from the low three address lines
  localparam logic [2:0] PORT_CORE_CMD    = 3'h0;
  localparam logic [2:0] PORT_CORE_SECTOR = 3'h2;
  localparam logic [2:0] PORT_CORE_DATA   = 3'h3;
  localparam logic [2:0] PORT_STATUS      = 3'h4;
  localparam logic [2:0] PORT_CONTROL     = 3'h5;
  // values loaded by bus reset
  localparam logic [7:0] CORE_CMD_RESET    = 8'h03;
  localparam logic [7:0] CORE_SECTOR_RESET = 8'h01;
  localparam logic [7:0] CTL_RESET         = 8'h00;
  // status port bit positions
  localparam int STAT_CORE_INTERRUPT_REQUEST    = 0;
  localparam int STAT_MOTOR    = 1;
  localparam int STAT_TPI96    = 3;
  localparam int STAT_PRECOMP  = 4;
  localparam int STAT_TWOSIDED = 6;
  localparam int STAT_DRQ      = 7;
  // access delay after data request, in system clocks
  localparam logic [1:0] DELAY_SHORT = 2'h1;
  localparam logic [1:0] DELAY_LONG  = 2'h2;

  // bus pins sampled by the board
  typedef struct packed {
    logic [7:0] addr;     // address lines a7..a0
    logic [7:0] dataOut;  // data from the master
    logic       sOut;     // output cycle status
    logic       sInp;     // input cycle status
    logic       pSync;    // cycle start
    logic       pStvalN;  // status valid, active low
    logic       pDbin;    // read strobe
    logic       pWrN;     // write strobe, active low
  } s100_in_t;

  // drive status pins and clock jumper
  typedef struct packed {
    logic motorOn;     // spindle running
    logic tpi96;       // 96 track-per-inch drives
    logic precompNeed; // drives need precompensation
    logic twoSided;    // two-sided medium
    logic waitTwoClk;  // jumper: count two clocks
  } drive_stat_t;

  // drive control latch, bit 7 down to bit 0
  typedef struct packed {
    logic       singleDensity; // 1 = single density
    logic       waitMode;      // wait_mode_bit
    logic       fastStep;      // fast_step_select
    logic       precompOff;    // 1 = precompensation off
    logic       driveEnable;   // 0 = deselect all
    logic       size8;         // 1 = 8 inch interface
    logic [1:0] driveSel;      // drive number
  } ctl_t;

  typedef enum logic [1:0] {W_IDLE, W_DRQ, W_DELAY} wait_state_t;
endpackage
`default_nettype wire

/* File: sim/fdc_host_port_test.sv */
// self-checking bench for host port, reset and wait-state logic
`default_nettype none
module fdc_host_port_test
  import fdc_port_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] BOARD = 5'h0a; // address switch setting
  logic        clk_sys, rst_n, coreDrq, coreIntrq, coreWriteGate;      // clock, reset, core pins
  logic        dataInOe, rdyOut, rdyOe, intOut, coreRd, coreWr;        // bus side outputs
  logic        coreResetN, coreNotReady, coreRestore, driveWriteGate;  // core side outputs
  logic        precompEnable, pllPhase4;                              // drive side outputs
  logic [7:0]  dataIn, coreReadData, coreWriteData, coreCmdPreset, coreSectorPreset; // byte paths
  logic [4:0]  boardAddr;  // address switch
  logic [3:0]  sel5, sel8; // drive selects
  logic [1:0]  coreAddr;   // core register select
  logic [8:0]  r;          // last read {oe, data}
  s100_in_t    busIn;      // bus pins
  drive_stat_t driveStat;  // drive status pins
  ctl_t        ctlOut;     // control latch
  int          errCount, checkCount; // mismatches, comparisons
  int          cnt [2];    // RDY release delay per jumper

  fdc_host_port u_fdc_host_port (.clk_sys, .rst_n, .busIn, .boardAddr, .driveStat, .dataIn, .dataInOe,
    .rdyOut, .rdyOe, .intOut, .coreReadData, .coreDrq, .coreIntrq, .coreWriteGate, .coreWriteData,
    .coreAddr, .coreRd, .coreWr, .coreResetN, .coreCmdPreset, .coreSectorPreset, .coreNotReady,
    .coreRestore, .ctlOut, .sel5, .sel8, .driveWriteGate, .precompEnable, .pllPhase4);
  s100_master_model cpu (.clk_sys, .busIn, .rdyOe, .rdyOut, .dataIn, .dataInOe);

  // 100 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // count a comparison, report a mismatch at once
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errCount++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // single exit point of the run
  task automatic results;
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // status byte as the board should present it
  function automatic logic [7:0] statusExp(drive_stat_t s, logic irq, logic core_data_request);
    return {core_data_request, s.twoSided, 1'b0, s.precompNeed, s.tpi96, 1'b0, s.motorOn, irq};
  endfunction

  // expected {sel8, sel5}: one-hot only while drives enabled
  function automatic logic [7:0] selExp(ctl_t c);
    logic [3:0] h;
    h = c.driveEnable ? 4'h1 << c.driveSel : 4'h0;
    return c.size8 ? {h, 4'h0} : {4'h0, h};
  endfunction

  // read through the master; data must be driven and match
  task automatic readCheck(input logic [2:0] port, input logic [7:0] exp);
    cpu.cycle(1'b0, {BOARD, port}, 8'h00, r);
    check({7'h0, r[8]}, 8'h01);
    check(r[7:0], exp);
  endtask

  // hold reset, check defined state, count restore pulses after release
  task automatic resetPulse(input int n);
    int p;
    rst_n = 1'b0;
    repeat (n) @(negedge clk_sys);
    check(ctlOut, CTL_RESET);
    check(coreCmdPreset, CORE_CMD_RESET);
    check(coreSectorPreset, CORE_SECTOR_RESET);
    check({4'h0, coreNotReady, pllPhase4, rdyOe, coreResetN}, 8'h00);
    rst_n = 1'b1;
    p = 0;
    repeat (8)
    begin
      @(negedge clk_sys);
      p += coreRestore;
    end
    check(8'(p), 8'h01);
  endtask

  // watchdog sized well above the expected run
  initial
  begin
    repeat (6000) @(posedge clk_sys);
    errCount++;
    results();
  end

  // main sequence
  initial
  begin
    ctl_t c;
    drive_stat_t s;
    logic [7:0] v;
    errCount = 0;
    checkCount = 0;
    void'($urandom(32'ha63f3f60));
    boardAddr = BOARD;
    driveStat = '0;
    coreReadData = 8'h00;
    coreDrq = 1'b0;
    coreIntrq = 1'b0;
    coreWriteGate = 1'b0;
    resetPulse(12);
    // status reads with random drive and core pins
    repeat (8)
    begin
      s = 5'($urandom);
      driveStat = s;
      coreDrq = 1'($urandom);
      coreIntrq = 1'($urandom);
      readCheck(PORT_STATUS, statusExp(s, coreIntrq, coreDrq));
    end
    coreIntrq = 1'b0;
    coreDrq = 1'b0;
    // every drive number on both interfaces, then all deselected
    for (int i = 0; i < 9; i++)
    begin
      c = 8'($urandom);
      c.waitMode = 1'b0;
      c.driveEnable = i < 8;
      {c.size8, c.driveSel} = i[2:0];
      coreWriteGate = c.driveEnable & 1'($urandom);
      cpu.cycle(1'b1, {BOARD, PORT_CONTROL}, c, r);
      check(ctlOut, c);
      check(coreWriteData, c);
      check({sel8, sel5}, selExp(c));
      check({5'h0, driveWriteGate, pllPhase4, precompEnable}, {5'h0, coreWriteGate,
        c.driveEnable & !c.singleDensity, coreWriteGate & !c.singleDensity & !c.precompOff});
    end
    // read-only status port, foreign board, input cycle
    cpu.cycle(1'b1, {BOARD, PORT_STATUS}, 8'ha5, r);
    check(ctlOut, c);
    check(coreWriteData, 8'ha5);
    cpu.cycle(1'b1, {~BOARD, PORT_CONTROL}, 8'h5a, r);
    coreReadData = 8'($urandom);
    readCheck(PORT_CORE_DATA, coreReadData);
    check(ctlOut, c);
    check(coreWriteData, 8'ha5);
    check({6'h0, coreAddr}, 8'h03);
    // RDY held until data request, release delay set by jumper
    for (int j = 0; j < 2; j++)
    begin
      driveStat.waitTwoClk = j[0];
      cpu.cycle(1'b1, {BOARD, PORT_CONTROL}, 8'h48, r);
      coreReadData = 8'($urandom);
      fork
        cpu.cycle(1'b0, {BOARD, PORT_CORE_DATA}, 8'h00, r);
        begin
          repeat (12) @(negedge clk_sys);
          check({5'h0, rdyOe, rdyOut, coreRd}, 8'h04);
          coreDrq = 1'b1;
          cnt[j] = 0;
          while (rdyOe === 1'b1 && cnt[j] < 20)
          begin
            @(negedge clk_sys);
            cnt[j]++;
          end
          // core read strobe opens once the wait has ended
          check({7'h0, coreRd}, 8'h01);
        end
      join
      check(r[7:0], coreReadData);
      coreDrq = 1'b0;
    end
    check(8'(cnt[1] - cnt[0]), 8'h01);
    check({7'h0, cnt[0] > 0 && cnt[0] < 4}, 8'h01);
    // core interrupt ends a pending wait and reaches the master
    fork
      cpu.cycle(1'b1, {BOARD, PORT_CORE_DATA}, 8'h3c, r);
      begin
        repeat (12) @(negedge clk_sys);
        check({7'h0, rdyOe}, 8'h01);
        coreIntrq = 1'b1;
        repeat (2) @(negedge clk_sys);
        check({5'h0, rdyOe, intOut, coreWr}, 8'h03);
      end
    join
    coreIntrq = 1'b0;
    // command image written, then bus reset in the middle of a wait
    v = 8'($urandom);
    cpu.cycle(1'b1, {BOARD, PORT_CORE_CMD}, v, r);
    check(coreCmdPreset, v);
    cpu.cycle(1'b1, {BOARD, PORT_CORE_SECTOR}, ~v, r);
    check(coreSectorPreset, ~v);
    fork
      cpu.cycle(1'b0, {BOARD, PORT_CORE_DATA}, 8'h00, r);
      begin
        repeat (12) @(negedge clk_sys);
        check({7'h0, rdyOe}, 8'h01);
        resetPulse(2);
      end
    join
    results();
  end
endmodule
`default_nettype wire

/* File: sim/s100_master_model.sv */
// behavioural bus master running single i/o cycles against the board
`default_nettype none
module s100_master_model
  import fdc_port_pkg::*;
(
  input  wire logic       clk_sys,  // bus system clock
  output var  s100_in_t   busIn,    // pins driven by the master
  input  wire logic       rdyOe,    // board pulls RDY low
  input  wire logic       rdyOut,   // level the board puts on RDY
  input  wire logic [7:0] dataIn,   // data from the board
  input  wire logic       dataInOe  // board drives data-in
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic rdyLine = rdyOe ? rdyOut : 1'b1; // pull-up when released

  // idle bus: no status, strobes inactive
  initial
  begin
    // one assignment: only the two active-low strobes sit high
    busIn = s100_in_t'(22'h000005);
  end

  // one cycle; pins change on falling edges only, r is {oe, data}
  task automatic cycle(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [8:0] r);
    int n;
    busIn.addr = a;
    busIn.sOut = wr;
    busIn.sInp = !wr;
    busIn.dataOut = wr ? d : ~busIn.dataOut; // undriven lines never keep a value
    busIn.pSync = 1'b1;
    busIn.pStvalN = 1'b0;
    @(negedge clk_sys);
    busIn.pSync = 1'b0;
    busIn.pStvalN = 1'b1;
    repeat (2) @(negedge clk_sys);
    busIn.pWrN = !wr;
    busIn.pDbin = !wr;
    repeat (4) @(negedge clk_sys);
    n = 0;
    // strobe held while RDY is low, bounded so a stuck wait cannot hang us
    while (rdyLine !== 1'b1 && n < 400)
    begin
      @(negedge clk_sys);
      n++;
    end
    repeat (5) @(negedge clk_sys);
    r = {dataInOe, dataIn};
    busIn.pWrN = 1'b1;
    busIn.pDbin = 1'b0;
    busIn.sOut = 1'b0;
    busIn.sInp = 1'b0;
    busIn.addr = ~a;
    busIn.dataOut = ~busIn.dataOut;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire
